/* core/irmod_pkg.sv */
// Constants shared by the infrared remote-control unit.
package irmod_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int IDX_W = 15;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CFG = 15'h5340;
    localparam logic [IDX_W-1:0] IDX_PSC = 15'h5341;
    localparam logic [IDX_W-1:0] IDX_CARH = 15'h5342;
    localparam logic [IDX_W-1:0] IDX_CARL = 15'h5343;
    localparam logic [IDX_W-1:0] IDX_DATA = 15'h5344;
    localparam logic [IDX_W-1:0] IDX_LCNT = 15'h5345;
    localparam logic [IDX_W-1:0] IDX_MASK = 15'h5346;
    localparam logic [IDX_W-1:0] IDX_FLAG = 15'h5347;
    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_RX_BIT = 1;
    localparam int PSC_CG_LSB = 4;
    localparam int PSC_LC_LSB = 0;
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_RSVD = 4'hF;
    localparam int PERIOD_W = 6;
    localparam int LEN_W = 8;
    localparam int EV_W = 3;
    localparam int EV_FALL = 2;
    localparam int EV_RISE = 1;
    localparam int EV_UNDER = 0;
    localparam int PRE_W = 14;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 6'h00;
    localparam logic [LEN_W-1:0] LEN_RESET = 8'h00;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;
endpackage

/* core/irmod_prescale.sv */
// Power-of-two tick generator for the carrier and length clocks.
`timescale 1ns/1ps
module irmod_prescale (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic [irmod_pkg::SEL_W-1:0] sel,
    // Divided clock as a one-cycle tick
    output logic tick
);
    logic [irmod_pkg::PRE_W-1:0] count;
    logic [irmod_pkg::PRE_W-1:0] next_count;
    logic [irmod_pkg::PRE_W-1:0] mask;
    logic next_tick;

    // The counter is held cleared while idle so each start is phase aligned.
    always_comb begin
        mask = (irmod_pkg::PRE_W'(1) << sel) - irmod_pkg::PRE_W'(1);
        next_count = run ? irmod_pkg::PRE_W'(count + 1'b1) : '0;
        next_tick = run && (sel != irmod_pkg::SEL_RSVD) && ((count & mask) == mask);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

/* core/irmod_top.sv */
// Infrared remote-control carrier modulator with AXI4-Lite registers.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module irmod_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // AXI4-Lite write channels
    input wire logic [irmod_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [irmod_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Infrared pins and interrupt request
    input wire logic irRxPin,
    output logic modOutPin,
    output logic irqReq
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic awHeld, wHeld, wLane0;
    logic [irmod_pkg::IDX_W-1:0] awIdx;
    logic [7:0] wByte;
    logic next_awHeld, next_wHeld, next_wLane0, next_awready, next_wready;
    logic [irmod_pkg::IDX_W-1:0] next_awIdx;
    logic [7:0] next_wByte;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wrFire, wrHit;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp, skResp, next_skResp;
    logic next_rvalid, skValid, next_skValid, next_arready;
    logic [7:0] skData, next_skData, rdByte;
    logic rdHit, arFire;
    logic cfgEn, cfgRx, next_cfgEn, next_cfgRx;
    logic [irmod_pkg::SEL_W-1:0] cgSel, lcSel, next_cgSel, next_lcSel;
    logic [irmod_pkg::PERIOD_W-1:0] highCount, lowCount, carCnt;
    logic [irmod_pkg::PERIOD_W-1:0] next_highCount, next_lowCount, next_carCnt;
    logic carPhase, next_carPhase, dataBit, next_dataBit;
    logic [irmod_pkg::LEN_W-1:0] lenCnt, next_lenCnt;
    logic lenRun, next_lenRun;
    logic [irmod_pkg::EV_W-1:0] mask, flags, next_mask, next_flags, events;
    logic next_modOut, next_irq;
    logic rxMeta, rxSync, rxPrev;
    logic cgTick, lcTick, wrData, wrLcnt, wrFlag, lastTick;

    // ------------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------------
    irmod_prescale carrierDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(cfgEn),
        .sel(cgSel),
        .tick(cgTick)
    );
    irmod_prescale lengthDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(cfgEn),
        .sel(lcSel),
        .tick(lcTick)
    );

    // ------------------------------------------------------------------
    // Write channel: address and data accepted in either order
    // ------------------------------------------------------------------
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awIdx = awIdx;
        next_wByte = wByte;
        next_wLane0 = wLane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        wrFire = awHeld && wHeld && !bvalid;
        case (awIdx)
            irmod_pkg::IDX_CFG, irmod_pkg::IDX_PSC, irmod_pkg::IDX_CARH,
            irmod_pkg::IDX_CARL, irmod_pkg::IDX_DATA, irmod_pkg::IDX_LCNT,
            irmod_pkg::IDX_MASK, irmod_pkg::IDX_FLAG: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awIdx = awaddr[irmod_pkg::ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wByte = wdata[7:0];
            next_wLane0 = wstrb[0];
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wrFire) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wrHit ? irmod_pkg::RESP_OKAY : irmod_pkg::RESP_SLVERR;
        end
        next_awready = !next_awHeld;
        next_wready = !next_wHeld;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awIdx <= '0;
            wByte <= 8'h00;
            wLane0 <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= irmod_pkg::RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awIdx <= next_awIdx;
            wByte <= next_wByte;
            wLane0 <= next_wLane0;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // ------------------------------------------------------------------
    // Read channel with a one-entry buffer before rdata
    // ------------------------------------------------------------------
    always_comb begin
        arFire = arvalid && arready;
        rdHit = 1'b1;
        rdByte = 8'h00;
        case (araddr[irmod_pkg::ADDR_W-1:2])
            irmod_pkg::IDX_CFG: rdByte = {6'h00, cfgRx, cfgEn};
            irmod_pkg::IDX_PSC: rdByte = {cgSel, lcSel};
            irmod_pkg::IDX_CARH: rdByte = {2'h0, highCount};
            irmod_pkg::IDX_CARL: rdByte = {2'h0, lowCount};
            irmod_pkg::IDX_DATA: rdByte = {7'h00, dataBit};
            irmod_pkg::IDX_LCNT: rdByte = lenCnt;
            irmod_pkg::IDX_MASK: rdByte = {5'h00, mask};
            irmod_pkg::IDX_FLAG: rdByte = {5'h00, flags};
            default: rdHit = 1'b0;
        endcase
        next_rdata = rdata;
        next_rresp = rresp;
        next_rvalid = rvalid;
        next_skValid = skValid;
        next_skData = skData;
        next_skResp = skResp;
        if (rvalid && rready) begin
            if (skValid) begin
                next_rdata = {24'h000000, skData};
                next_rresp = skResp;
                next_skValid = 1'b0;
            end else begin
                next_rvalid = 1'b0;
            end
        end
        if (arFire) begin
            if (!next_rvalid) begin
                next_rdata = {24'h000000, rdByte};
                next_rresp = rdHit ? irmod_pkg::RESP_OKAY : irmod_pkg::RESP_SLVERR;
                next_rvalid = 1'b1;
            end else begin
                next_skData = rdByte;
                next_skResp = rdHit ? irmod_pkg::RESP_OKAY : irmod_pkg::RESP_SLVERR;
                next_skValid = 1'b1;
            end
        end
        // A stalled reader fills the spare entry, then address accept stops.
        next_arready = !next_skValid;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
            rresp <= irmod_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            skValid <= 1'b0;
            skData <= 8'h00;
            skResp <= irmod_pkg::RESP_OKAY;
            arready <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rresp <= next_rresp;
            rvalid <= next_rvalid;
            skValid <= next_skValid;
            skData <= next_skData;
            skResp <= next_skResp;
            arready <= next_arready;
        end
    end

    // ------------------------------------------------------------------
    // Carrier, length counter, receive edges and flags
    // ------------------------------------------------------------------
    always_comb begin
        wrData = wrFire && wLane0 && (awIdx == irmod_pkg::IDX_DATA);
        wrLcnt = wrFire && wLane0 && (awIdx == irmod_pkg::IDX_LCNT);
        wrFlag = wrFire && wLane0 && (awIdx == irmod_pkg::IDX_FLAG);
        lastTick = lcTick && lenRun && (lenCnt == 8'h01);
        next_cfgEn = cfgEn;
        next_cfgRx = cfgRx;
        next_cgSel = cgSel;
        next_lcSel = lcSel;
        next_highCount = highCount;
        next_lowCount = lowCount;
        next_mask = mask;
        if (wrFire && wLane0) begin
            case (awIdx)
                irmod_pkg::IDX_CFG: begin
                    next_cfgEn = wByte[irmod_pkg::CFG_EN_BIT];
                    next_cfgRx = wByte[irmod_pkg::CFG_RX_BIT];
                end
                irmod_pkg::IDX_PSC: begin
                    next_cgSel = wByte[irmod_pkg::PSC_CG_LSB +: irmod_pkg::SEL_W];
                    next_lcSel = wByte[irmod_pkg::PSC_LC_LSB +: irmod_pkg::SEL_W];
                end
                irmod_pkg::IDX_CARH: next_highCount = wByte[5:0];
                irmod_pkg::IDX_CARL: next_lowCount = wByte[5:0];
                irmod_pkg::IDX_MASK: next_mask = wByte[2:0];
                default: next_mask = mask;
            endcase
        end
        next_carPhase = carPhase;
        next_carCnt = carCnt;
        if (!cfgEn) begin
            next_carPhase = 1'b1;
            next_carCnt = highCount;
        end else if (cgTick) begin
            if (carCnt == 6'h00) begin
                next_carPhase = !carPhase;
                next_carCnt = carPhase ? lowCount : highCount;
            end else begin
                next_carCnt = carCnt - 6'h01;
            end
        end
        next_dataBit = wrData ? wByte[0] : dataBit;
        if (cfgEn && cfgRx) begin
            next_dataBit = rxSync;
        end
        next_lenCnt = lenCnt;
        next_lenRun = lenRun;
        if (lcTick && lenRun) begin
            next_lenCnt = lenCnt - 8'h01;
            next_lenRun = !lastTick;
        end
        if (wrLcnt) begin
            next_lenCnt = wByte;
            next_lenRun = (wByte != 8'h00);
        end
        events[irmod_pkg::EV_FALL] = cfgEn && cfgRx && !rxSync && rxPrev;
        events[irmod_pkg::EV_RISE] = cfgEn && cfgRx && rxSync && !rxPrev;
        events[irmod_pkg::EV_UNDER] = lastTick;
        // An unmasked cause in the same cycle as its clear keeps the flag set.
        next_flags = (flags & ~(wrFlag ? wByte[2:0] : 3'h0)) | (events & mask);
        next_irq = |next_flags;
        next_modOut = cfgEn && !cfgRx && dataBit && carPhase;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfgEn <= 1'b0;
            cfgRx <= 1'b0;
            cgSel <= irmod_pkg::SEL_RESET;
            lcSel <= irmod_pkg::SEL_RESET;
            highCount <= irmod_pkg::PERIOD_RESET;
            lowCount <= irmod_pkg::PERIOD_RESET;
            carCnt <= irmod_pkg::PERIOD_RESET;
            carPhase <= 1'b1;
            dataBit <= 1'b0;
            lenCnt <= irmod_pkg::LEN_RESET;
            lenRun <= 1'b0;
            mask <= irmod_pkg::EV_RESET;
            flags <= irmod_pkg::EV_RESET;
            irqReq <= 1'b0;
            modOutPin <= 1'b0;
            rxMeta <= 1'b0;
            rxSync <= 1'b0;
            rxPrev <= 1'b0;
        end else begin
            cfgEn <= next_cfgEn;
            cfgRx <= next_cfgRx;
            cgSel <= next_cgSel;
            lcSel <= next_lcSel;
            highCount <= next_highCount;
            lowCount <= next_lowCount;
            carCnt <= next_carCnt;
            carPhase <= next_carPhase;
            dataBit <= next_dataBit;
            lenCnt <= next_lenCnt;
            lenRun <= next_lenRun;
            mask <= next_mask;
            flags <= next_flags;
            irqReq <= next_irq;
            modOutPin <= next_modOut;
            rxMeta <= irRxPin;
            rxSync <= rxMeta;
            rxPrev <= rxSync;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence phaseEnd;
        cfgEn && cgTick && (carCnt == 6'h00);
    endsequence
    sequence countDone;
        lastTick ##1 (!lenRun && lenCnt == 8'h00);
    endsequence

    high_period_a: assert property (phaseEnd and carPhase |=> !carPhase && carCnt == $past(lowCount))
        else $error("carrier high phase did not hand over to low count");
    low_period_a: assert property (phaseEnd and !carPhase |=> carPhase && carCnt == $past(highCount))
        else $error("carrier low phase did not hand over to high count");
    mod_output_a: assert property (cfgEn && !cfgRx && dataBit && carPhase |=> modOutPin)
        else $error("modulated output missing");
    data_low_a: assert property (!dataBit |=> !modOutPin)
        else $error("output not low for data zero");
    rx_sample_a: assert property (cfgEn && cfgRx |=> dataBit == $past(rxSync))
        else $error("received level not copied");
    len_load_a: assert property (wrLcnt |=> lenCnt == $past(wByte) && lenRun == ($past(wByte) != 8'h00))
        else $error("length counter load wrong");
    len_stop_a: assert property (lastTick && mask[0] && !wrLcnt |-> countDone ##0 flags[0])
        else $error("underflow did not stop counter or set flag");
    rise_flag_a: assert property (events[1] && mask[1] |=> flags[1] ##0 irqReq)
        else $error("rising edge flag or request missing");
    mask_gate_a: assert property (!flags[2] && !mask[2] |=> !flags[2])
        else $error("masked falling edge set its flag");
    irq_level_a: assert property (irqReq == (flags != 3'h0))
        else $error("interrupt request disagrees with flags");
    flag_clear_a: assert property (wrFlag && wByte[0] && !events[0] |=> !flags[0])
        else $error("flag not cleared by writing one");
    rsvd_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("reserved read bits not zero");
endmodule

/* tb/irmod_far_end.sv */
// Far-side emitter and receiver model for the infrared unit.
`timescale 1ns/1ps
module irmod_far_end (
    // Clock
    input wire logic core_clk,
    // Emitter side
    input wire logic modOutPin,
    output logic [7:0] highRun,
    output logic [7:0] lowRun,
    // Receiver side
    input wire logic rxLevel,
    output logic irRxPin
);
    // ------------------------------------------------------------------
    // Run-length meter
    // ------------------------------------------------------------------
    // Only finished runs are reported, so a half-seen period never shows.
    logic [7:0] runLen = 8'h00;
    logic lastLevel = 1'b0;
    initial begin
        highRun = 8'h00;
        lowRun = 8'h00;
    end
    assign irRxPin = rxLevel;
    always @(posedge core_clk) begin
        if (modOutPin !== lastLevel) begin
            if (lastLevel) begin
                highRun <= runLen;
            end else begin
                lowRun <= runLen;
            end
            runLen <= 8'h01;
        end else begin
            runLen <= runLen + 8'h01;
        end
        lastLevel <= modOutPin;
    end
endmodule

/* tb/ir_remote_carrier_modulator_tb.sv */
// Self-checking bench for the infrared remote-control unit.
`timescale 1ns/1ps
module ir_remote_carrier_modulator_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [16:0] awaddr = 17'h00000;
    logic [16:0] araddr = 17'h00000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic rxLevel = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irRxPin, modOutPin, irqReq;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] highRun;
    logic [7:0] lowRun;
    logic [31:0] d;
    logic [1:0] r;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    always #50 core_clk = ~core_clk;
    irmod_top i_dut (
        .core_clk(core_clk), .resetn(resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irRxPin(irRxPin), .modOutPin(modOutPin), .irqReq(irqReq)
    );
    irmod_far_end i_far (
        .core_clk(core_clk), .modOutPin(modOutPin), .highRun(highRun),
        .lowRun(lowRun), .rxLevel(rxLevel), .irRxPin(irRxPin)
    );
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are judged at the falling edge, where registered readies are settled.
    task automatic wr(input logic [14:0] idx, input logic [7:0] v, input logic [1:0] er);
        logic a;
        logic w;
        logic ha;
        logic hw;
        logic bv;
        @(posedge core_clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        a = 1'b0;
        w = 1'b0;
        while (!(a && w)) begin
            @(negedge core_clk);
            ha = awready && !a;
            hw = wready && !w;
            @(posedge core_clk);
            if (ha) begin
                awvalid <= 1'b0;
                a = 1'b1;
            end
            if (hw) begin
                wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        do begin
            @(negedge core_clk);
            bv = bvalid;
            r = bresp;
            @(posedge core_clk);
        end while (bv !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [14:0] idx);
        logic ok;
        @(posedge core_clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ok = arready;
            @(posedge core_clk);
        end while (ok !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(negedge core_clk);
            ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
        end while (ok !== 1'b1);
        rready <= 1'b0;
    endtask
    task automatic rdChk(input logic [14:0] idx, input logic [7:0] e);
        rd(idx);
        chk(d, {24'h000000, e});
        chk({30'h0, r}, {30'h0, irmod_pkg::RESP_OKAY});
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            rdChk(irmod_pkg::IDX_CARH + 15'(i), 8'h00);
        end
        wr(irmod_pkg::IDX_CARH, 8'hFF, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_CARH, 8'h3F);
        wr(irmod_pkg::IDX_CARL, 8'hC5, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_CARL, 8'h05);
        wr(irmod_pkg::IDX_DATA, 8'hFE, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_DATA, 8'h00);
        wr(irmod_pkg::IDX_MASK, 8'hFF, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_MASK, 8'h07);
        // A write without byte lane zero must leave the register alone.
        wstrb <= 4'h0;
        wr(irmod_pkg::IDX_CARH, 8'h11, irmod_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rdChk(irmod_pkg::IDX_CARH, 8'h3F);
        rd(15'h5348);
        chk({30'h0, r}, {30'h0, irmod_pkg::RESP_SLVERR});
        wr(15'h5348, 8'h01, irmod_pkg::RESP_SLVERR);
        // Carrier shape at three divider codes, changed only while disabled.
        wr(irmod_pkg::IDX_CARH, 8'h02, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_CARL, 8'h04, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_DATA, 8'h01, irmod_pkg::RESP_OKAY);
        for (int c = 0; c < 3; c++) begin
            wr(irmod_pkg::IDX_CFG, 8'h00, irmod_pkg::RESP_OKAY);
            wr(irmod_pkg::IDX_PSC, {4'(c), 4'h0}, irmod_pkg::RESP_OKAY);
            wr(irmod_pkg::IDX_CFG, 8'h01, irmod_pkg::RESP_OKAY);
            repeat (150) @(posedge core_clk);
            chk({24'h0, highRun}, 32'(3 << c));
            chk({24'h0, lowRun}, 32'(5 << c));
        end
        wr(irmod_pkg::IDX_DATA, 8'h00, irmod_pkg::RESP_OKAY);
        repeat (5) @(posedge core_clk);
        for (int i = 0; i < 30; i++) begin
            @(negedge core_clk);
            chk({31'h0, modOutPin}, 32'h0);
        end
        // Length counter with the divide-by-eight clock.
        wr(irmod_pkg::IDX_CFG, 8'h00, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_PSC, 8'h03, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_FLAG, 8'h07, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_MASK, 8'h01, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_CFG, 8'h01, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_LCNT, 8'h20, irmod_pkg::RESP_OKAY);
        rd(irmod_pkg::IDX_LCNT);
        chk({31'h0, (d[7:0] inside {[8'h1C:8'h20]})}, 32'h1);
        repeat (300) @(posedge core_clk);
        rdChk(irmod_pkg::IDX_LCNT, 8'h00);
        rdChk(irmod_pkg::IDX_FLAG, 8'h01);
        // The bench stands in for the interrupt controller with this unit enabled.
        chk({31'h0, irqReq}, 32'h1);
        wr(irmod_pkg::IDX_FLAG, 8'h01, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_FLAG, 8'h00);
        chk({31'h0, irqReq}, 32'h0);
        // A masked underflow sets no flag, and the carrier keeps running.
        wr(irmod_pkg::IDX_DATA, 8'h01, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_MASK, 8'h00, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_LCNT, 8'h02, irmod_pkg::RESP_OKAY);
        repeat (60) @(posedge core_clk);
        rdChk(irmod_pkg::IDX_FLAG, 8'h00);
        chk({24'h0, highRun}, 32'h3);
        // Receive mode: input level, both edges and a measured pulse.
        wr(irmod_pkg::IDX_MASK, 8'h06, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_CFG, 8'h03, irmod_pkg::RESP_OKAY);
        rxLevel <= 1'b1;
        repeat (10) @(posedge core_clk);
        rdChk(irmod_pkg::IDX_DATA, 8'h01);
        rdChk(irmod_pkg::IDX_FLAG, 8'h02);
        wr(irmod_pkg::IDX_LCNT, 8'hFF, irmod_pkg::RESP_OKAY);
        repeat (80) @(posedge core_clk);
        rxLevel <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(irmod_pkg::IDX_LCNT);
        chk({31'h0, ((8'hFF - d[7:0]) inside {[8'h0A:8'h0D]})}, 32'h1);
        rdChk(irmod_pkg::IDX_DATA, 8'h00);
        rdChk(irmod_pkg::IDX_FLAG, 8'h06);
        wr(irmod_pkg::IDX_FLAG, 8'h02, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_FLAG, 8'h04);
        wr(irmod_pkg::IDX_FLAG, 8'h04, irmod_pkg::RESP_OKAY);
        rdChk(irmod_pkg::IDX_FLAG, 8'h00);
        chk({31'h0, irqReq}, 32'h0);
        // The reserved clock code gives no ticks, so a loaded count stays put.
        wr(irmod_pkg::IDX_CFG, 8'h00, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_PSC, 8'h0F, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_CFG, 8'h01, irmod_pkg::RESP_OKAY);
        wr(irmod_pkg::IDX_LCNT, 8'h02, irmod_pkg::RESP_OKAY);
        repeat (40) @(posedge core_clk);
        rdChk(irmod_pkg::IDX_LCNT, 8'h02);
        test_done();
    end
endmodule
